/* src/irq_pkg.sv */
// constants, register map and carrier types of the prioritized interrupt unit
// assumes a 32-bit axi4-lite register bus and a core that reports its cycles
package irq_pkg;
   localparam int NUM_SRC = 13;
   localparam int ADDR_W = 8;
   // register byte offsets
   localparam logic [7:0] OFS_IRQ_ENABLE = 8'h00;
   localparam logic [7:0] OFS_PRIO_LOW = 8'h04;
   localparam logic [7:0] OFS_PRIO_HIGH = 8'h08;
   localparam logic [7:0] OFS_CTRL = 8'h0C;
   localparam logic [7:0] OFS_FLAGS = 8'h10;
   localparam logic [7:0] OFS_STATUS = 8'h14;
   // control register bit positions
   localparam int CTRL_GLOBAL_EN = 0;
   localparam int CTRL_PF_EN = 1;
   localparam int CTRL_WD_RESET_EN = 2;
   localparam int CTRL_EXT0_EDGE = 3;
   localparam int CTRL_EXT1_EDGE = 4;
   // flag register bit positions
   localparam int FLG_EXT0 = 0;
   localparam int FLG_TMR0 = 1;
   localparam int FLG_EXT1 = 2;
   localparam int FLG_TMR1 = 3;
   localparam int FLG_RX0 = 4;
   localparam int FLG_TX0 = 5;
   localparam int FLG_TMR2 = 6;
   localparam int FLG_TMR2_EXT = 7;
   localparam int FLG_RX1 = 8;
   localparam int FLG_TX1 = 9;
   localparam int FLG_EXT2 = 10;
   localparam int FLG_WDOG = 14;
   localparam int FLG_PF = 15;
   // reset values
   localparam logic [11:0] RST_ENABLE = 12'h000;
   localparam logic [11:0] RST_PRIO = 12'h000;
   localparam logic [4:0] RST_CTRL = 5'h00;
   localparam logic [14:0] RST_FLAGS = 15'h0000;
   // external pins 2 and 4 react to rising edges, the rest to falling
   localparam logic [5:0] EXT_RISING = 6'h14;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // source index = natural order, index 0 is power-fail
   localparam logic [NUM_SRC-1:0][7:0] VECTOR_TABLE = {
      8'h63, 8'h5B, 8'h53, 8'h4B, 8'h43, 8'h3B, 8'h2B,
      8'h23, 8'h1B, 8'h13, 8'h0B, 8'h03, 8'h33};

   typedef struct packed {
      logic [ADDR_W-1:0] awaddr;
      logic awvalid;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic wvalid;
      logic bready;
      logic [ADDR_W-1:0] araddr;
      logic arvalid;
      logic rready;
   } axil_req_t;

   typedef struct packed {
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } axil_rsp_t;

   typedef struct packed {
      logic final_cycle;
      logic is_return_from_interrupt;
      logic writes_cfg;
   } core_evt_t;

   typedef struct packed {
      logic tmr0_ovf;
      logic tmr1_ovf;
      logic tmr2_ovf;
      logic tmr2_ext;
      logic rx0_done;
      logic tx0_done;
      logic rx1_done;
      logic tx1_done;
      logic wdog_event;
   } periph_evt_t;

   typedef struct packed {
      logic req;
      logic [7:0] vector;
      logic [3:0] source;
   } call_t;

   typedef struct packed {
      logic [5:0] pin_s1;
      logic [5:0] pin_s2;
      logic [5:0] pin_prev;
      logic pf_s1;
      logic pf_s2;
      logic [14:0] flags;
      logic [11:0] enable;
      logic [11:0] prio_lo;
      logic [11:0] prio_hi;
      logic [4:0] ctrl;
      logic cfg_dirty;
      logic [4:0] in_service;
      call_t call;
      logic aw_got;
      logic w_got;
      logic [ADDR_W-1:0] aw_addr;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      axil_rsp_t bus;
   } state_t;
endpackage : irq_pkg

/* src/prioritized_interrupt_unit.sv */
// prioritized interrupt unit: flags, arbitration over five levels, vectoring
// assumes a core that flags final cycles, returns and config writes, and
// peripherals that pulse one cycle per completed event on aclk
//
// Added by the designer: register access over AXI4-Lite and the register addresses.
`timescale 1ns/10ps
module prioritized_interrupt_unit (
   input wire logic aclk,
   input wire logic aresetn,
   input wire irq_pkg::axil_req_t axi_req,
   output irq_pkg::axil_rsp_t axi_rsp,
   input wire irq_pkg::core_evt_t core_evt,
   input wire irq_pkg::periph_evt_t periph_evt,
   input wire logic [5:0] ext_pin,
   input wire logic supply_below_warn,
   output irq_pkg::call_t call,
   output logic [4:0] in_service,
   output logic watchdog_reset_enable
);
   import irq_pkg::*;

   state_t s;
   state_t next_s;

   function automatic logic [31:0] merge_bytes(input logic [31:0] old,
                                               input logic [31:0] data,
                                               input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            r[8*b +: 8] = data[8*b +: 8];
         end
      end
      return r;
   endfunction : merge_bytes

   // level code plus one, zero means nothing in service
   function automatic logic [2:0] top_level(input logic [4:0] isv);
      logic [2:0] r;
      r = 3'h0;
      for (int l = 0; l < 5; l++) begin
         if (isv[l]) begin
            r = 3'(l + 1);
         end
      end
      return r;
   endfunction : top_level

   logic [NUM_SRC-1:0] src_req;
   logic [5:0] rise;
   logic [5:0] fall;
   logic [5:0] edge_hit;
   logic [2:0] isv_top;
   logic [2:0] best;
   logic [3:0] sel;
   logic [2:0] cand;
   logic gate;
   logic take;
   logic aw_fire;
   logic w_fire;
   logic ar_fire;
   logic do_write;
   logic [ADDR_W-1:0] wa;
   logic [31:0] rd;
   logic rd_ok;
   logic [14:0] flag_set;
   logic [14:0] flag_clr;
   logic [31:0] merged;
   logic [31:0] old_word;

   always_comb begin
      next_s = s;
      // pin edges are taken only from the second synchroniser stage
      rise = s.pin_s2 & ~s.pin_prev;
      fall = ~s.pin_s2 & s.pin_prev;
      edge_hit = (rise & EXT_RISING) | (fall & ~EXT_RISING);

      // request per source in natural order
      gate = s.ctrl[CTRL_GLOBAL_EN];
      src_req[0] = s.pf_s2 & s.ctrl[CTRL_PF_EN];
      src_req[1] = s.flags[FLG_EXT0];
      src_req[2] = s.flags[FLG_TMR0];
      src_req[3] = s.flags[FLG_EXT1];
      src_req[4] = s.flags[FLG_TMR1];
      src_req[5] = s.flags[FLG_RX0] | s.flags[FLG_TX0];
      src_req[6] = s.flags[FLG_TMR2] | s.flags[FLG_TMR2_EXT];
      src_req[7] = s.flags[FLG_RX1] | s.flags[FLG_TX1];
      for (int i = 0; i < 4; i++) begin
         src_req[8 + i] = s.flags[FLG_EXT2 + i];
      end
      src_req[12] = s.flags[FLG_WDOG];
      for (int i = 1; i < NUM_SRC; i++) begin
         src_req[i] = src_req[i] & s.enable[i-1] & gate;
      end

      // arbitration: highest level wins, lower index on a tie
      isv_top = top_level(s.in_service);
      best = 3'h0;
      sel = 4'h0;
      for (int i = NUM_SRC - 1; i >= 0; i--) begin
         cand = (i == 0) ? 3'h5 : {1'b0, s.prio_hi[i-1], s.prio_lo[i-1]} + 3'h1;
         if (src_req[i] && cand > isv_top && cand >= best) begin
            best = cand;
            sel = 4'(i);
         end
      end
      take = core_evt.final_cycle && !core_evt.is_return_from_interrupt
             && !core_evt.writes_cfg && !s.cfg_dirty
             && best != 3'h0;

      // one-cycle call strobe, the core spends three cycles on the call
      next_s.call.req = take;
      if (take) begin
         next_s.call.vector = VECTOR_TABLE[sel];
         next_s.call.source = sel;
      end

      // in-service tracking
      if (core_evt.final_cycle && core_evt.is_return_from_interrupt && isv_top != 3'h0) begin
         next_s.in_service[isv_top - 3'h1] = 1'b0;
      end
      if (take) begin
         next_s.in_service[best - 3'h1] = 1'b1;
      end
      if (core_evt.final_cycle) begin
         next_s.cfg_dirty = 1'b0;
      end

      // hardware flag sources
      flag_set = '0;
      flag_set[FLG_EXT0] = edge_hit[0] & s.ctrl[CTRL_EXT0_EDGE];
      flag_set[FLG_EXT1] = edge_hit[1] & s.ctrl[CTRL_EXT1_EDGE];
      flag_set[FLG_TMR0] = periph_evt.tmr0_ovf;
      flag_set[FLG_TMR1] = periph_evt.tmr1_ovf;
      flag_set[FLG_TMR2] = periph_evt.tmr2_ovf;
      flag_set[FLG_TMR2_EXT] = periph_evt.tmr2_ext;
      flag_set[FLG_RX0] = periph_evt.rx0_done;
      flag_set[FLG_TX0] = periph_evt.tx0_done;
      flag_set[FLG_RX1] = periph_evt.rx1_done;
      flag_set[FLG_TX1] = periph_evt.tx1_done;
      for (int i = 0; i < 4; i++) begin
         flag_set[FLG_EXT2 + i] = edge_hit[2 + i];
      end
      flag_set[FLG_WDOG] = periph_evt.wdog_event;
      flag_clr = '0;
      if (take) begin
         flag_clr[FLG_TMR0] = (sel == 4'h2);
         flag_clr[FLG_TMR1] = (sel == 4'h4);
         flag_clr[FLG_EXT0] = (sel == 4'h1) & s.ctrl[CTRL_EXT0_EDGE];
         flag_clr[FLG_EXT1] = (sel == 4'h3) & s.ctrl[CTRL_EXT1_EDGE];
      end

      // bus write channel
      aw_fire = axi_req.awvalid & s.bus.awready;
      w_fire = axi_req.wvalid & s.bus.wready;
      if (aw_fire) begin
         next_s.aw_got = 1'b1;
         next_s.aw_addr = axi_req.awaddr;
      end
      if (w_fire) begin
         next_s.w_got = 1'b1;
         next_s.wdata = axi_req.wdata;
         next_s.wstrb = axi_req.wstrb;
      end
      if (s.bus.bvalid && axi_req.bready) begin
         next_s.bus.bvalid = 1'b0;
      end
      do_write = s.aw_got & s.w_got & ~s.bus.bvalid;
      wa = {s.aw_addr[ADDR_W-1:2], 2'b00};
      case (wa)
         OFS_IRQ_ENABLE: old_word = {20'h00000, s.enable};
         OFS_PRIO_LOW: old_word = {20'h00000, s.prio_lo};
         OFS_PRIO_HIGH: old_word = {20'h00000, s.prio_hi};
         OFS_CTRL: old_word = {27'h0000000, s.ctrl};
         OFS_FLAGS: old_word = {17'h00000, s.flags};
         default: old_word = 32'h00000000;
      endcase
      merged = merge_bytes(old_word, s.wdata, s.wstrb);
      if (do_write) begin
         next_s.aw_got = 1'b0;
         next_s.w_got = 1'b0;
         next_s.bus.bvalid = 1'b1;
         next_s.bus.bresp = RESP_OKAY;
         case (wa)
            OFS_IRQ_ENABLE: begin
               next_s.enable = merged[11:0];
               next_s.cfg_dirty = 1'b1;
            end
            OFS_PRIO_LOW: begin
               next_s.prio_lo = merged[11:0];
               next_s.cfg_dirty = 1'b1;
            end
            OFS_PRIO_HIGH: begin
               next_s.prio_hi = merged[11:0];
               next_s.cfg_dirty = 1'b1;
            end
            OFS_CTRL: begin
               next_s.ctrl = merged[4:0];
               next_s.cfg_dirty = 1'b1;
            end
            OFS_FLAGS: next_s.flags = merged[14:0];
            OFS_STATUS: ;
            default: next_s.bus.bresp = RESP_SLVERR;
         endcase
      end
      // hardware events land after the software value so none is lost
      next_s.flags = (next_s.flags & ~flag_clr) | flag_set;
      // level-mode pins are not latched: the flag is the inverted synchronised pin
      if (!s.ctrl[CTRL_EXT0_EDGE]) begin
         next_s.flags[FLG_EXT0] = ~s.pin_s2[0];
      end
      if (!s.ctrl[CTRL_EXT1_EDGE]) begin
         next_s.flags[FLG_EXT1] = ~s.pin_s2[1];
      end
      next_s.bus.awready = ~next_s.aw_got;
      next_s.bus.wready = ~next_s.w_got;

      // bus read channel
      ar_fire = axi_req.arvalid & s.bus.arready;
      rd_ok = 1'b1;
      case ({axi_req.araddr[ADDR_W-1:2], 2'b00})
         OFS_IRQ_ENABLE: rd = {20'h00000, s.enable};
         OFS_PRIO_LOW: rd = {20'h00000, s.prio_lo};
         OFS_PRIO_HIGH: rd = {20'h00000, s.prio_hi};
         OFS_CTRL: rd = {27'h0000000, s.ctrl};
         OFS_FLAGS: rd = {16'h0000, s.pf_s2, s.flags};
         OFS_STATUS: rd = {20'h00000, s.call.source, 3'h0, s.in_service};
         default: begin
            rd = 32'h00000000;
            rd_ok = 1'b0;
         end
      endcase
      if (s.bus.rvalid && axi_req.rready) begin
         next_s.bus.rvalid = 1'b0;
      end
      if (ar_fire) begin
         next_s.bus.rvalid = 1'b1;
         next_s.bus.rdata = rd;
         next_s.bus.rresp = rd_ok ? RESP_OKAY : RESP_SLVERR;
      end
      next_s.bus.arready = ~next_s.bus.rvalid;

      // synchronisers for pins and comparator
      next_s.pin_s1 = ext_pin;
      next_s.pin_s2 = s.pin_s1;
      next_s.pin_prev = s.pin_s2;
      next_s.pf_s1 = supply_below_warn;
      next_s.pf_s2 = s.pf_s1;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s <= '0;
         s.pin_s1 <= 6'h3F;
         s.pin_s2 <= 6'h3F;
         s.pin_prev <= 6'h3F;
         s.flags <= RST_FLAGS;
         s.enable <= RST_ENABLE;
         s.prio_lo <= RST_PRIO;
         s.prio_hi <= RST_PRIO;
         s.ctrl <= RST_CTRL;
      end else begin
         s <= next_s;
      end
   end

   assign axi_rsp = s.bus;
   assign call = s.call;
   assign in_service = s.in_service;
   // the watchdog reset path stays independent of the interrupt flag
   assign watchdog_reset_enable = s.ctrl[CTRL_WD_RESET_EN];
endmodule : prioritized_interrupt_unit

/* verification/irq_chk.sv */
// checker for the interrupt unit: call strobe, blocking, service levels
// sees only the top ports; bound to every instance at the foot of the file
`timescale 1ns/10ps
module irq_chk import irq_pkg::*; (
   input wire logic aclk,
   input wire logic aresetn,
   input wire core_evt_t core_evt,
   input wire call_t call,
   input wire logic [4:0] in_service
);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   sequence return_from_interrupt_s;
      core_evt.final_cycle && core_evt.is_return_from_interrupt && in_service != 5'h00;
   endsequence
   sequence cfg_s;
      core_evt.final_cycle && core_evt.writes_cfg;
   endsequence
   req_pulse_a: assert property (call.req |=> !call.req)
      else $error("call strobe longer than one cycle");
   nonfinal_block_a: assert property (!core_evt.final_cycle |=> !call.req)
      else $error("call after a non-final cycle");
   return_from_interrupt_block_a: assert property (core_evt.final_cycle && core_evt.is_return_from_interrupt
      |=> !call.req)
      else $error("call after a return");
   cfg_block_a: assert property (cfg_s |=> !call.req)
      else $error("call after a config write");
   vec_map_a: assert property (call.req
      |-> call.vector == VECTOR_TABLE[call.source])
      else $error("vector does not match source");
   pf_level_a: assert property (call.req && call.source == 4'h0
      |-> in_service[4])
      else $error("power-fail not at top level");
   preempt_a: assert property (call.req |-> $onehot(in_service
      ^ $past(in_service)) && (in_service ^ $past(in_service))
      > $past(in_service))
      else $error("preemption without strictly higher level");
   return_from_interrupt_clear_a: assert property (return_from_interrupt_s |=> $onehot($past(in_service)
      ^ in_service) && ($past(in_service) ^ in_service) > in_service)
      else $error("return did not clear the top level");
   isv_cause_a: assert property ($changed(in_service) |-> call.req
      || $past(core_evt.final_cycle && core_evt.is_return_from_interrupt))
      else $error("service level changed without cause");
endmodule : irq_chk

bind prioritized_interrupt_unit irq_chk u_chk (.aclk(aclk),
   .aresetn(aresetn), .core_evt(core_evt), .call(call),
   .in_service(in_service));

/* verification/core_model.sv */
// model of the core: four-cycle instructions, returns, config writes
// assumes the bench holds return_from_interrupt_req until it sees the return taken
`timescale 1ns/10ps
module core_model import irq_pkg::*; (
   input wire logic aclk,
   input wire logic aresetn,
   input wire call_t call,
   input wire logic return_from_interrupt_req,
   output core_evt_t core_evt
);
   logic [1:0] phase;
   logic [1:0] long_subroutine_call;
   logic [1:0] nfin;
   logic fin;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         phase <= 2'h0;
         long_subroutine_call <= 2'h0;
         nfin <= 2'h0;
      end else if (call.req) begin
         long_subroutine_call <= 2'h3;
      end else if (long_subroutine_call != 2'h0) begin
         long_subroutine_call <= long_subroutine_call - 2'h1;
      end else begin
         phase <= phase + 2'h1;
         if (fin) nfin <= nfin + 2'h1;
      end
   end
   // no final cycle while the forced call runs
   assign fin = aresetn && long_subroutine_call == 2'h0 && !call.req && phase == 2'h3;
   assign core_evt.final_cycle = fin;
   assign core_evt.is_return_from_interrupt = fin && return_from_interrupt_req;
   // occasional config write, never on a return
   assign core_evt.writes_cfg = fin && !return_from_interrupt_req && nfin == 2'h2;
endmodule : core_model

/* verification/prioritized_interrupt_unit_tb.sv */
// self-checking bench: register bus master, pins, pulses, core model
// assumes a 100 ns clock and the package register map
`timescale 1ns/10ps
module prioritized_interrupt_unit_tb;
   import irq_pkg::*;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic return_from_interrupt_req = 1'b0;
   logic [5:0] ext_pin = 6'h2B;
   logic supply_below_warn = 1'b0;
   axil_req_t axi_req = '0;
   axil_rsp_t axi_rsp;
   periph_evt_t periph_evt = '0;
   core_evt_t core_evt;
   call_t call;
   logic [4:0] in_service;
   logic wd_rst;
   logic [31:0] rd;
   logic [1:0] rsp;
   logic [1:0] wrsp;
   int n_fail = 0;
   int compares = 0;
   int isv = 0;
   int start;
   int vec[13] = '{8'h33, 8'h03, 8'h0B, 8'h13, 8'h1B, 8'h23, 8'h2B,
      8'h3B, 8'h43, 8'h4B, 8'h53, 8'h5B, 8'h63};
   int lvl[13] = '{0: 4, default: 0};
   int fbit[13] = '{15, 0, 1, 2, 3, 4, 6, 8, 10, 11, 12, 13, 14};
   logic [7:0] regs[6] = '{OFS_IRQ_ENABLE, OFS_PRIO_LOW, OFS_PRIO_HIGH,
      OFS_CTRL, OFS_FLAGS, OFS_STATUS};
   always #50 aclk = ~aclk;
   prioritized_interrupt_unit DUT (.aclk(aclk), .aresetn(aresetn),
      .axi_req(axi_req), .axi_rsp(axi_rsp), .core_evt(core_evt),
      .periph_evt(periph_evt), .ext_pin(ext_pin),
      .supply_below_warn(supply_below_warn), .call(call),
      .in_service(in_service), .watchdog_reset_enable(wd_rst));
   core_model core (.aclk(aclk), .aresetn(aresetn), .call(call),
      .return_from_interrupt_req(return_from_interrupt_req), .core_evt(core_evt));
   task chk(input string name, input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (e !== g) begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", name, e, g);
      end
   endtask : chk
   task wr(input logic [7:0] a, input logic [31:0] d);
      logic aw;
      logic w;
      aw = 1'b1;
      w = 1'b1;
      axi_req.awaddr <= a;
      axi_req.wdata <= d;
      axi_req.wstrb <= 4'hF;
      axi_req.awvalid <= 1'b1;
      axi_req.wvalid <= 1'b1;
      while (aw || w) begin
         @(posedge aclk);
         aw = aw && axi_rsp.awready !== 1'b1;
         w = w && axi_rsp.wready !== 1'b1;
         axi_req.awvalid <= aw;
         axi_req.wvalid <= w;
      end
      while (axi_rsp.bvalid !== 1'b1) @(posedge aclk);
      wrsp = axi_rsp.bresp;
   endtask : wr
   task rdr(input logic [7:0] a);
      axi_req.araddr <= a;
      axi_req.arvalid <= 1'b1;
      @(posedge aclk);
      while (axi_rsp.arready !== 1'b1) @(posedge aclk);
      axi_req.arvalid <= 1'b0;
      @(posedge aclk);
      while (axi_rsp.rvalid !== 1'b1) @(posedge aclk);
      rd = axi_rsp.rdata;
      rsp = axi_rsp.rresp;
   endtask : rdr
   task wait_call(input int s);
      int n;
      n = 0;
      while (call.req !== 1'b1 && n < 60) begin
         @(posedge aclk);
         n++;
      end
      // a call that never came must not pass on stale vector fields
      if (call.req !== 1'b1) begin
         n_fail++;
         $display("wrong value call timeout expected 1 seen 0");
      end
      isv = isv | (1 << lvl[s]);
      chk("vector", vec[s], call.vector);
      chk("source", s, call.source);
      chk("in_service", isv, in_service);
   endtask : wait_call
   task return_from_interrupt();
      return_from_interrupt_req <= 1'b1;
      @(posedge aclk);
      while (!(core_evt.final_cycle && core_evt.is_return_from_interrupt)) @(posedge aclk);
      return_from_interrupt_req <= 1'b0;
      for (int i = 4; i >= 0; i--) begin
         if (isv[i]) begin
            isv[i] = 0;
            break;
         end
      end
      @(posedge aclk);
      chk("in_service", isv, in_service);
   endtask : return_from_interrupt
   task quiet(input int n);
      repeat (n) begin
         @(posedge aclk);
         chk("no call", 0, call.req);
      end
   endtask : quiet
   task results();
      $display("compares %0d n_fail %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : results
   initial begin
      axi_req.bready = 1'b1;
      axi_req.rready = 1'b1;
      void'($urandom(53));
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (2) @(posedge aclk);
      foreach (regs[i]) begin
         rdr(regs[i]);
         chk("reset value", 0, rd);
      end
      rdr(8'h40);
      chk("unmapped resp", RESP_SLVERR, rsp);
      wr(8'h40, 32'h1);
      chk("unmapped wresp", RESP_SLVERR, wrsp);
      wr(OFS_CTRL, 32'h19);
      wr(OFS_IRQ_ENABLE, 32'hFFF);
      chk("write resp", RESP_OKAY, wrsp);
      start = $urandom % 12;
      for (int k = 0; k < 12; k++) begin
         int s;
         s = 1 + (start + k) % 12;
         wr(OFS_FLAGS, 32'h1 << fbit[s]);
         wait_call(s);
         rdr(OFS_FLAGS);
         chk("flags", (s < 5) ? 0 : 32'h1 << fbit[s], rd);
         wr(OFS_FLAGS, 32'h0);
         return_from_interrupt();
      end
      // equal levels: natural order picks, the loser waits
      wr(OFS_FLAGS, 32'h4002);
      wait_call(2);
      quiet(20);
      wr(OFS_PRIO_LOW, 32'h10);
      lvl[5] = 1;
      wr(OFS_FLAGS, 32'h4010);
      wait_call(5);
      wr(OFS_FLAGS, 32'h4000);
      return_from_interrupt();
      quiet(12);
      return_from_interrupt();
      wait_call(12);
      wr(OFS_FLAGS, 32'h0);
      return_from_interrupt();
      // one-cycle tx1_done pulse from uart 1 raises its shared request
      periph_evt.tx1_done <= 1'b1;
      @(posedge aclk);
      periph_evt.tx1_done <= 1'b0;
      wait_call(7);
      rdr(OFS_FLAGS);
      chk("flags", 32'h200, rd);
      wr(OFS_FLAGS, 32'h0);
      return_from_interrupt();
      // hardware pulse held off by global enable, then cancelled
      wr(OFS_CTRL, 32'h18);
      periph_evt.tmr1_ovf <= 1'b1;
      @(posedge aclk);
      periph_evt.tmr1_ovf <= 1'b0;
      quiet(12);
      wr(OFS_FLAGS, 32'h0);
      wr(OFS_CTRL, 32'h19);
      quiet(20);
      ext_pin[0] <= 1'b0;
      wait_call(1);
      ext_pin[0] <= 1'b1;
      return_from_interrupt();
      // level mode with global enable off: flag follows the inverted pin
      wr(OFS_CTRL, 32'h10);
      ext_pin[0] <= 1'b0;
      repeat (5) @(posedge aclk);
      rdr(OFS_FLAGS);
      chk("level flag", 32'h1, rd);
      ext_pin[0] <= 1'b1;
      repeat (5) @(posedge aclk);
      rdr(OFS_FLAGS);
      chk("level flag", 32'h0, rd);
      // power-fail ignores global enable, sits at the top level
      wr(OFS_CTRL, 32'h06);
      chk("wd reset en", 1, wd_rst);
      supply_below_warn <= 1'b1;
      wait_call(0);
      rdr(OFS_FLAGS);
      chk("pf level", 32'h8000, rd);
      supply_below_warn <= 1'b0;
      repeat (5) @(posedge aclk);
      return_from_interrupt();
      wr(OFS_CTRL, 32'h00);
      quiet(10);
      results();
   end
   initial begin
      repeat (20000) @(posedge aclk);
      n_fail++;
      results();
   end
endmodule : prioritized_interrupt_unit_tb
